// *** core/ipd_pkg.sv ***
// Constants and types for the indexed postbyte decoder
package ipd_pkg;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] PAGE2_PREFIX = 8'h18;
	localparam logic [1:0] SEL_INDEX_X = 2'h0;
	localparam logic [1:0] SEL_INDEX_Y = 2'h1;
	localparam logic [1:0] SEL_STACK = 2'h2;
	localparam logic [1:0] SEL_PROGRAM = 2'h3;
	localparam logic [15:0] RESET_ADDR = 16'h0000;
	localparam int POINTER_READ_CYCLES = 1;

	typedef enum logic [2:0] {
		IPD_OFS_CONST5 = 3'h0,
		IPD_OFS_CONST9 = 3'h1,
		IPD_OFS_CONST16 = 3'h2,
		IPD_OFS_ACC_HI = 3'h3,
		IPD_OFS_ACC_LO = 3'h4,
		IPD_OFS_ACC_D = 3'h5,
		IPD_OFS_AUTO = 3'h6
	} ipd_ofs_t;

	typedef enum logic [1:0] {
		IPD_IDLE = 2'b00,
		IPD_EXT = 2'b01,
		IPD_PTR = 2'b11,
		IPD_DONE = 2'b10
	} ipd_state_t;
endpackage : ipd_pkg

// *** core/ipd_field_decode.sv ***
// Combinational split of one indexed postbyte into its fields
module ipd_field_decode (
	input wire logic [7:0] index_postbyte,
	output ipd_pkg::ipd_ofs_t offset_kind,
	output logic [1:0] base_register_select,
	output logic [1:0] ext_count,
	output logic indirect,
	output logic auto_adjust,
	output logic auto_post,
	output logic [15:0] small_offset,
	output logic illegal
);
	timeunit 1ns;
	timeprecision 100ps;
	always_comb begin
		base_register_select = index_postbyte[7:6];
		offset_kind = ipd_pkg::IPD_OFS_CONST5;
		ext_count = 2'h0;
		indirect = 1'b0;
		auto_adjust = 1'b0;
		auto_post = 1'b0;
		small_offset = 16'h0000;
		illegal = 1'b0;
		if (!index_postbyte[5]) begin
			small_offset = {{11{index_postbyte[4]}}, index_postbyte[4:0]};
		end else if (index_postbyte[7:5] != 3'h7) begin
			offset_kind = ipd_pkg::IPD_OFS_AUTO;
			auto_adjust = 1'b1;
			auto_post = index_postbyte[4];
			// Nibble 0..7 is +1..+8, 8..F is -8..-1
			small_offset = index_postbyte[3] ? {12'hFFF, index_postbyte[3:0]}
				: {12'h000, index_postbyte[3:0]} + 16'h0001;
			illegal = (index_postbyte[7:6] == ipd_pkg::SEL_PROGRAM);
		end else begin
			base_register_select = index_postbyte[4:3];
			if (!index_postbyte[2]) begin
				if (!index_postbyte[1]) begin
					offset_kind = ipd_pkg::IPD_OFS_CONST9;
					ext_count = 2'h1;
					small_offset = {{8{index_postbyte[0]}}, 8'h00};
				end else begin
					offset_kind = ipd_pkg::IPD_OFS_CONST16;
					ext_count = 2'h2;
					indirect = index_postbyte[0];
				end
			end else begin
				case (index_postbyte[1:0])
					2'h0: offset_kind = ipd_pkg::IPD_OFS_ACC_HI;
					2'h1: offset_kind = ipd_pkg::IPD_OFS_ACC_LO;
					2'h2: offset_kind = ipd_pkg::IPD_OFS_ACC_D;
					default: begin
						offset_kind = ipd_pkg::IPD_OFS_ACC_D;
						indirect = 1'b1;
					end
				endcase
			end
		end
	end
endmodule : ipd_field_decode

// *** core/ipd_decoder.sv ***
// Indexed postbyte decoder and effective address former
// Summary of operation
// - Indexed instruction is opcode, one postbyte, then zero to two extension bytes.
// - Postbyte rr0nnnnn gives signed 5-bit offset, any base, no extension.
// - Postbyte 111rr0zs gives 9-bit offset plus one byte, or 16-bit plus two.
// - Postbyte 111rr011 gives 16-bit offset indexed-indirect, two extension bytes.
// - Postbyte rr1pnnnn adjusts base pre or post by 1..8; no program counter.
// - Postbyte 111rr1aa adds high, low or double accumulator; 11 is indirect.
// - Opcodes are 8-bit; page-two prefix redirects next opcode to second map.
// - Postbytes follow indexed opcodes; extension bytes consumed as operands.
// - Indirect forms read 16-bit pointer at base plus offset as address.
// - Direct forms other than post-adjust add base register and constant or accumulator offset; post-adjust gives the base alone.
module ipd_decoder (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic opcode_is_indexed,
	output logic byte_ready,
	input wire logic [15:0] index_x,
	input wire logic [15:0] index_y,
	input wire logic [15:0] stack_pointer,
	input wire logic [15:0] program_counter,
	input wire logic [7:0] acc_hi,
	input wire logic [7:0] acc_lo,
	output logic [7:0] opcode,
	output logic opcode_page2,
	output logic opcode_strobe,
	output logic ptr_req,
	output logic [15:0] ptr_addr,
	input wire logic ptr_valid,
	input wire logic [15:0] ptr_data,
	output logic ea_valid,
	output logic [15:0] effective_address,
	output logic [1:0] base_register_select,
	output logic auto_adjust,
	output logic auto_post,
	output logic [15:0] adjusted_base,
	output logic illegal_postbyte
);
	timeunit 1ns;
	timeprecision 100ps;
	ipd_pkg::ipd_state_t state;
	ipd_pkg::ipd_state_t next_state;
	logic expect_postbyte;
	logic page2_seen;
	logic [7:0] postbyte;
	logic [1:0] ext_left;
	logic [15:0] ext_value;
	ipd_pkg::ipd_ofs_t dec_kind;
	logic [1:0] dec_sel;
	logic [1:0] dec_ext;
	logic dec_ind;
	logic dec_auto;
	logic dec_post;
	logic [15:0] dec_small;
	logic dec_illegal;
	logic [15:0] base_value;
	logic [15:0] offset_value;
	logic [15:0] sum;
	logic take;
	logic ext_loaded;

	ipd_field_decode u_fields (
		.index_postbyte(postbyte),
		.offset_kind(dec_kind),
		.base_register_select(dec_sel),
		.ext_count(dec_ext),
		.indirect(dec_ind),
		.auto_adjust(dec_auto),
		.auto_post(dec_post),
		.small_offset(dec_small),
		.illegal(dec_illegal)
	);

	// Bytes accepted only while gathering, so address forming never overlaps
	// Refused while the count loads, else a byte would be dropped
	assign byte_ready = (state == ipd_pkg::IPD_IDLE)
		|| (state == ipd_pkg::IPD_EXT && !ext_loaded && ext_left != 2'h0);
	assign take = byte_valid && byte_ready;

	always_comb begin
		case (dec_sel)
			ipd_pkg::SEL_INDEX_X: base_value = index_x;
			ipd_pkg::SEL_INDEX_Y: base_value = index_y;
			ipd_pkg::SEL_STACK: base_value = stack_pointer;
			default: base_value = program_counter;
		endcase
	end

	always_comb begin
		case (dec_kind)
			ipd_pkg::IPD_OFS_CONST9: offset_value = {dec_small[15:8], ext_value[7:0]};
			ipd_pkg::IPD_OFS_CONST16: offset_value = ext_value;
			ipd_pkg::IPD_OFS_ACC_HI: offset_value = {8'h00, acc_hi};
			ipd_pkg::IPD_OFS_ACC_LO: offset_value = {8'h00, acc_lo};
			ipd_pkg::IPD_OFS_ACC_D: offset_value = {acc_hi, acc_lo};
			default: offset_value = dec_small;
		endcase
	end

	assign sum = base_value + offset_value;

	always_comb begin
		next_state = state;
		case (state)
			ipd_pkg::IPD_IDLE: begin
				if (take && expect_postbyte) begin
					next_state = ipd_pkg::IPD_EXT;
				end
			end
			ipd_pkg::IPD_EXT: begin
				if (!ext_loaded && ext_left == 2'h0) begin
					next_state = dec_ind ? ipd_pkg::IPD_PTR : ipd_pkg::IPD_DONE;
				end
			end
			ipd_pkg::IPD_PTR: begin
				if (ptr_valid) begin
					next_state = ipd_pkg::IPD_DONE;
				end
			end
			ipd_pkg::IPD_DONE: next_state = ipd_pkg::IPD_IDLE;
			default: next_state = ipd_pkg::IPD_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ipd_pkg::IPD_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			page2_seen <= 1'b0;
			opcode <= 8'h00;
			opcode_page2 <= 1'b0;
			opcode_strobe <= 1'b0;
			expect_postbyte <= 1'b0;
		end else begin
			opcode_strobe <= 1'b0;
			if (take && state == ipd_pkg::IPD_IDLE && !expect_postbyte) begin
				if (byte_data == ipd_pkg::PAGE2_PREFIX && !page2_seen) begin
					page2_seen <= 1'b1;
				end else begin
					opcode <= byte_data;
					opcode_page2 <= page2_seen;
					opcode_strobe <= 1'b1;
					page2_seen <= 1'b0;
					expect_postbyte <= opcode_is_indexed;
				end
			end else if (take && expect_postbyte) begin
				expect_postbyte <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			postbyte <= 8'h00;
			ext_left <= 2'h0;
			ext_value <= 16'h0000;
		end else if (take && state == ipd_pkg::IPD_IDLE && expect_postbyte) begin
			postbyte <= byte_data;
			ext_value <= 16'h0000;
			ext_left <= 2'h0;
		end else if (state == ipd_pkg::IPD_EXT) begin
			if (ext_loaded) begin
				ext_left <= dec_ext;
			end else if (take && ext_left != 2'h0) begin
				ext_value <= {ext_value[7:0], byte_data};
				ext_left <= ext_left - 2'h1;
			end
		end
	end

	// Extension count loads the cycle after the postbyte lands
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_loaded <= 1'b0;
		end else begin
			ext_loaded <= take && state == ipd_pkg::IPD_IDLE && expect_postbyte;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_req <= 1'b0;
			ptr_addr <= ipd_pkg::RESET_ADDR;
			ea_valid <= 1'b0;
			effective_address <= ipd_pkg::RESET_ADDR;
			base_register_select <= ipd_pkg::SEL_INDEX_X;
			auto_adjust <= 1'b0;
			auto_post <= 1'b0;
			adjusted_base <= 16'h0000;
			illegal_postbyte <= 1'b0;
		end else begin
			ea_valid <= 1'b0;
			if (state == ipd_pkg::IPD_EXT && ext_left == 2'h0 && !ext_loaded) begin
				base_register_select <= dec_sel;
				auto_adjust <= dec_auto;
				auto_post <= dec_post;
				adjusted_base <= sum;
				illegal_postbyte <= dec_illegal;
				if (dec_ind) begin
					ptr_req <= 1'b1;
					ptr_addr <= sum;
				end else begin
					ea_valid <= 1'b1;
					effective_address <= (dec_auto && dec_post) ? base_value : sum;
				end
			end else if (state == ipd_pkg::IPD_PTR && ptr_valid) begin
				ptr_req <= 1'b0;
				ea_valid <= 1'b1;
				effective_address <= ptr_data;
			end
		end
	end

endmodule : ipd_decoder

// *** tb/ipd_decoder_chk.sv ***
// Port checker for the indexed postbyte decoder
module ipd_decoder_chk (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic byte_ready,
	input wire logic [7:0] byte_data,
	input wire logic [7:0] opcode,
	input wire logic opcode_strobe,
	input wire logic ptr_req,
	input wire logic [15:0] ptr_addr,
	input wire logic ptr_valid,
	input wire logic [15:0] ptr_data,
	input wire logic ea_valid,
	input wire logic [15:0] effective_address,
	input wire logic [1:0] base_register_select,
	input wire logic auto_adjust,
	input wire logic auto_post,
	input wire logic [15:0] adjusted_base
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	property p_hold; ptr_req && !ptr_valid |=> ptr_req; endproperty
	a_hold: assert property (p_hold) else $error("pointer request dropped");
	property p_addr; ptr_req && !ptr_valid |=> $stable(ptr_addr); endproperty
	a_addr: assert property (p_addr) else $error("pointer address moved");
	property p_ptr_ea; ptr_req && ptr_valid |=> ea_valid && effective_address == $past(ptr_data); endproperty
	a_ptr_ea: assert property (p_ptr_ea) else $error("pointer not used as address");
	property p_busy; ptr_req |-> !byte_ready; endproperty
	a_busy: assert property (p_busy) else $error("byte taken during pointer read");
	property p_pulse; ea_valid |=> !ea_valid; endproperty
	a_pulse: assert property (p_pulse) else $error("address strobe too long");
	property p_opc; opcode_strobe |-> opcode == $past(byte_data); endproperty
	a_opc: assert property (p_opc) else $error("opcode byte mismatch");
	property p_no_pc; auto_adjust |-> base_register_select != ipd_pkg::SEL_PROGRAM; endproperty
	a_no_pc: assert property (p_no_pc) else $error("auto adjust on program counter");
	property p_pre; ea_valid && auto_adjust && !auto_post |-> effective_address == adjusted_base; endproperty
	a_pre: assert property (p_pre) else $error("pre form address wrong");
	property p_post; ea_valid && auto_adjust && auto_post |-> effective_address != adjusted_base; endproperty
	a_post: assert property (p_post) else $error("post form address wrong");
	c_ind: cover property (ptr_req && ptr_valid);
	c_pre: cover property (ea_valid && auto_adjust && !auto_post);
	c_post: cover property (ea_valid && auto_adjust && auto_post);
endmodule : ipd_decoder_chk

bind ipd_decoder ipd_decoder_chk chk (.ref_clk, .sys_rst, .byte_ready, .byte_data, .opcode, .opcode_strobe,
	.ptr_req, .ptr_addr, .ptr_valid, .ptr_data, .ea_valid, .effective_address, .base_register_select,
	.auto_adjust, .auto_post, .adjusted_base);

// *** tb/ipd_queue_model.sv ***
// Model of the pointer-read side of the address datapath
module ipd_queue_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic ptr_req,
	input wire logic [15:0] ptr_addr,
	output logic ptr_valid,
	output logic [15:0] ptr_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] wait_cnt;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wait_cnt <= 3'h0;
			ptr_valid <= 1'b0;
		end else begin
			ptr_valid <= ptr_req && !ptr_valid && wait_cnt == (slow ? 3'h4 : 3'h0);
			wait_cnt <= (ptr_req && !ptr_valid) ? wait_cnt + 3'h1 : 3'h0;
		end
	end
	// Outside the answer cycle the data is not held
	assign ptr_data = ptr_valid ? ptr_addr ^ 16'hA5A5 : ~(ptr_addr ^ 16'hA5A5);
endmodule : ipd_queue_model

// *** tb/tb_top.sv ***
// Self-checking bench for the indexed postbyte decoder
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 0, sys_rst = 1, byte_valid = 0, opcode_is_indexed = 0, slow = 0;
	logic [7:0] byte_data = 8'h00, acc_hi = 8'h12, acc_lo = 8'hF4, opcode;
	logic [15:0] index_x = 16'h1000, index_y = 16'h2000, stack_pointer = 16'h3000, program_counter = 16'h4000;
	logic [15:0] ptr_addr, ptr_data, effective_address, adjusted_base;
	logic byte_ready, opcode_page2, opcode_strobe, ptr_req, ptr_valid, ea_valid, auto_adjust, auto_post;
	logic illegal_postbyte;
	logic [1:0] base_register_select;
	int fails = 0, n_compared = 0, cyc = 0;
	ipd_decoder dut (.ref_clk, .sys_rst, .byte_valid, .byte_data, .opcode_is_indexed, .byte_ready, .index_x,
		.index_y, .stack_pointer, .program_counter, .acc_hi, .acc_lo, .opcode, .opcode_page2, .opcode_strobe,
		.ptr_req, .ptr_addr, .ptr_valid, .ptr_data, .ea_valid, .effective_address, .base_register_select,
		.auto_adjust, .auto_post, .adjusted_base, .illegal_postbyte);
	ipd_queue_model partner (.ref_clk, .sys_rst, .slow, .ptr_req, .ptr_addr, .ptr_valid, .ptr_data);
	initial forever #12.5 ref_clk = ~ref_clk;
	task report_and_stop;
		if (fails == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	// Hang guard, well above the hundred or so cycles used
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			report_and_stop();
		end
	end
	task check(string what, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Valid stays up between bytes; run lowers it at the end
	task put(logic [7:0] b, logic idx);
		byte_valid = 1;
		byte_data = b;
		opcode_is_indexed = idx;
		while (byte_ready !== 1'b1) @(posedge ref_clk) #1;
		@(posedge ref_clk) #1;
	endtask : put
	task run(string what, logic [7:0] pb, int n, logic [15:0] ext, logic [15:0] exp);
		int k;
		put(8'hA6, 1);
		put(pb, 0);
		if (n == 2) put(ext[15:8], 0);
		if (n > 0) put(ext[7:0], 0);
		byte_valid = 0;
		for (k = 0; k < 20 && ea_valid !== 1'b1; k++) @(posedge ref_clk) #1;
		check(what, ea_valid === 1'b1 ? effective_address : 16'hDEAD, exp);
	endtask : run
	task t_const5;
		run("c5 y+15", 8'h4F, 0, 16'h0, 16'h200F);
		run("c5 x-16", 8'h10, 0, 16'h0, 16'h0FF0);
		run("c5 sp-1", 8'h9F, 0, 16'h0, 16'h2FFF);
		run("c5 pc+1", 8'hC1, 0, 16'h0, 16'h4001);
	endtask : t_const5
	task t_const_ext;
		run("c9 x-251", 8'hE1, 1, 16'h0005, 16'h0F05);
		run("c16 y", 8'hEA, 2, 16'h1234, 16'h3234);
	endtask : t_const_ext
	task t_indirect;
		slow = 1;
		run("ind16 sp", 8'hF3, 2, 16'h0010, 16'h95B5);
		slow = 0;
		run("ind d x", 8'hE7, 0, 16'h0, 16'h8751);
	endtask : t_indirect
	task t_acc;
		run("acc hi", 8'hE4, 0, 16'h0, 16'h1012);
		run("acc lo", 8'hE5, 0, 16'h0, 16'h10F4);
		run("acc d", 8'hE6, 0, 16'h0, 16'h22F4);
	endtask : t_acc
	task t_auto;
		run("pre +8", 8'h27, 0, 16'h0, 16'h1008);
		check("pre base", adjusted_base, 16'h1008);
		check("pre adjust", {15'h0, auto_adjust}, 16'h0001);
		check("pre flag", {15'h0, auto_post}, 16'h0000);
		run("post -8", 8'h38, 0, 16'h0, 16'h1000);
		check("post base", adjusted_base, 16'h0FF8);
		check("post flag", {15'h0, auto_post}, 16'h0001);
		run("pre sp -1", 8'hAF, 0, 16'h0, 16'h2FFF);
		check("auto sel", {14'h0, base_register_select}, {14'h0, ipd_pkg::SEL_STACK});
		check("auto legal", {15'h0, illegal_postbyte}, 16'h0000);
	endtask : t_auto
	task t_page2;
		put(ipd_pkg::PAGE2_PREFIX, 0);
		run("page2 c5", 8'h41, 0, 16'h0, 16'h2001);
		check("page2 flag", {15'h0, opcode_page2}, 16'h0001);
		check("page2 op", {8'h0, opcode}, 16'h00A6);
		run("page1 c5", 8'h41, 0, 16'h0, 16'h2001);
		check("page1 flag", {15'h0, opcode_page2}, 16'h0000);
	endtask : t_page2
	initial begin
		repeat (8) @(posedge ref_clk);
		#1 sys_rst = 0;
		t_const5();
		t_const_ext();
		t_indirect();
		t_acc();
		t_auto();
		t_page2();
		report_and_stop();
	end
endmodule : tb_top
